//--- gpc_pkg.sv
// Package with register map, field positions and reset values of the port block
package gpc_pkg;

    // ****************************************
    // Widths
    // ****************************************
    localparam int unsigned PORT_W = 8;
    localparam int unsigned GROUPS = 4;
    localparam int unsigned SRC_W = 32;
    localparam int unsigned ADDR_W = 9;
    localparam int unsigned IDX_W = 7;
    localparam int unsigned DATA_W = 8;

    // ****************************************
    // Register indices (byte address = 4 * index)
    // ****************************************
    localparam logic [6:0] IDX_INPUT_PINS = 7'h00;
    localparam logic [6:0] IDX_DIRECTION = 7'h01;
    localparam logic [6:0] IDX_OUTPUT_DATA = 7'h02;
    localparam logic [6:0] IDX_DIR_SET = 7'h03;
    localparam logic [6:0] IDX_DIR_CLEAR = 7'h04;
    localparam logic [6:0] IDX_OUT_SET = 7'h05;
    localparam logic [6:0] IDX_OUT_CLEAR = 7'h06;
    localparam logic [6:0] IDX_CORE_CONTROL = 7'h07;
    localparam logic [6:0] IDX_CPU_STATUS = 7'h08;
    localparam logic [6:0] IDX_GROUP_CONTROL = 7'h09;
    localparam logic [6:0] IDX_GROUP_FLAGS = 7'h0a;
    localparam logic [6:0] IDX_MASK_GROUP0 = 7'h0b;
    localparam logic [6:0] IDX_MASK_GROUP1 = 7'h0c;
    localparam logic [6:0] IDX_MASK_GROUP2 = 7'h6d;
    localparam logic [6:0] IDX_MASK_GROUP3 = 7'h73;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int unsigned POS_PULLUP_DISABLE = 4;
    localparam int unsigned POS_GLOBAL_IRQ_EN = 7;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] RST_DIRECTION = 8'h00;
    localparam logic [7:0] RST_OUTPUT_DATA = 8'h00;
    localparam logic [7:0] RST_MASK = 8'h00;
    localparam logic [7:0] RST_CORE_CONTROL = 8'h00;
    localparam logic [7:0] RST_CPU_STATUS = 8'h00;
    localparam logic [3:0] RST_GROUP_CONTROL = 4'h0;
    localparam logic [3:0] RST_GROUP_FLAGS = 4'h0;
    localparam logic [31:0] RST_SRC = 32'h0000_0000;
    localparam logic [7:0] RST_PINS = 8'h00;

endpackage

//--- gpc_port.sv
// General purpose 8-bit port with pin-change detection for four groups of eight sources
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module gpc_port (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [8:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe,
    output logic [7:0] pin_pullup,
    input wire logic [31:0] change_source_pins,
    input wire logic [3:0] vector_entered,
    output logic [3:0] vector_request,
    output logic [3:0] wake_request
);

    // ****************************************
    // Address decode
    // ****************************************
    function automatic logic hit(input logic [8:0] addr, input logic [6:0] idx);
        hit = (addr[1:0] == 2'h0) && (addr[8:2] == idx);
    endfunction

    logic wr_in;
    logic wr_dir;
    logic wr_out;
    logic wr_dir_set;
    logic wr_dir_clr;
    logic wr_out_set;
    logic wr_out_clr;
    logic wr_core;
    logic wr_cpu;
    logic wr_gctl;
    logic wr_flags;
    logic [3:0] wr_mask;

    assign wr_in = reg_wr && hit(reg_addr, gpc_pkg::IDX_INPUT_PINS);
    assign wr_dir = reg_wr && hit(reg_addr, gpc_pkg::IDX_DIRECTION);
    assign wr_out = reg_wr && hit(reg_addr, gpc_pkg::IDX_OUTPUT_DATA);
    assign wr_dir_set = reg_wr && hit(reg_addr, gpc_pkg::IDX_DIR_SET);
    assign wr_dir_clr = reg_wr && hit(reg_addr, gpc_pkg::IDX_DIR_CLEAR);
    assign wr_out_set = reg_wr && hit(reg_addr, gpc_pkg::IDX_OUT_SET);
    assign wr_out_clr = reg_wr && hit(reg_addr, gpc_pkg::IDX_OUT_CLEAR);
    assign wr_core = reg_wr && hit(reg_addr, gpc_pkg::IDX_CORE_CONTROL);
    assign wr_cpu = reg_wr && hit(reg_addr, gpc_pkg::IDX_CPU_STATUS);
    assign wr_gctl = reg_wr && hit(reg_addr, gpc_pkg::IDX_GROUP_CONTROL);
    assign wr_flags = reg_wr && hit(reg_addr, gpc_pkg::IDX_GROUP_FLAGS);
    assign wr_mask[0] = reg_wr && hit(reg_addr, gpc_pkg::IDX_MASK_GROUP0);
    assign wr_mask[1] = reg_wr && hit(reg_addr, gpc_pkg::IDX_MASK_GROUP1);
    assign wr_mask[2] = reg_wr && hit(reg_addr, gpc_pkg::IDX_MASK_GROUP2);
    assign wr_mask[3] = reg_wr && hit(reg_addr, gpc_pkg::IDX_MASK_GROUP3);

    // ****************************************
    // Port configuration registers
    // ****************************************
    logic [7:0] direction_q;
    logic [7:0] direction_d;
    logic [7:0] output_data_q;
    logic [7:0] output_data_d;
    logic [7:0] core_control_q;
    logic [7:0] cpu_status_q;
    logic pud_d;

    // Set and clear aliases touch only the bits written as one
    always_comb begin
        direction_d = direction_q;
        if (wr_dir) begin
            direction_d = reg_wdata;
        end else if (wr_dir_set) begin
            direction_d = direction_q | reg_wdata;
        end else if (wr_dir_clr) begin
            direction_d = direction_q & ~reg_wdata;
        end
    end

    always_comb begin
        output_data_d = output_data_q;
        if (wr_out) begin
            output_data_d = reg_wdata;
        end else if (wr_out_set) begin
            output_data_d = output_data_q | reg_wdata;
        end else if (wr_out_clr) begin
            output_data_d = output_data_q & ~reg_wdata;
        end else if (wr_in) begin
            output_data_d = output_data_q ^ reg_wdata;
        end
    end

    always_comb begin
        pud_d = core_control_q[gpc_pkg::POS_PULLUP_DISABLE];
        if (wr_core) begin
            pud_d = reg_wdata[gpc_pkg::POS_PULLUP_DISABLE];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            direction_q <= gpc_pkg::RST_DIRECTION;
            output_data_q <= gpc_pkg::RST_OUTPUT_DATA;
        end else begin
            direction_q <= direction_d;
            output_data_q <= output_data_d;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            core_control_q <= gpc_pkg::RST_CORE_CONTROL;
        end else if (wr_core) begin
            core_control_q <= reg_wdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cpu_status_q <= gpc_pkg::RST_CPU_STATUS;
        end else if (wr_cpu) begin
            cpu_status_q <= reg_wdata;
        end
    end

    // ****************************************
    // Pin drivers
    // ****************************************
    logic [7:0] oe_q;
    logic [7:0] pull_q;

    // Computed from next values so the pins follow the register without extra lag
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            oe_q <= gpc_pkg::RST_PINS;
            pin_out <= gpc_pkg::RST_PINS;
            pull_q <= gpc_pkg::RST_PINS;
        end else begin
            oe_q <= direction_d;
            pin_out <= output_data_d;
            pull_q <= ~direction_d & output_data_d & {8{~pud_d}};
        end
    end

    // Reset gates the drivers directly, since the clock may be stopped
    assign pin_oe = oe_q & {8{~sys_rst}};
    assign pin_pullup = pull_q & {8{~sys_rst}};

    // ****************************************
    // Input synchronisers
    // ****************************************
    logic [7:0] pin_meta_q;
    logic [7:0] pin_sync_q;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pin_meta_q <= gpc_pkg::RST_PINS;
            pin_sync_q <= gpc_pkg::RST_PINS;
        end else begin
            pin_meta_q <= pin_in;
            pin_sync_q <= pin_meta_q;
        end
    end

    logic [31:0] src_meta_q;
    logic [31:0] src_sync_q;
    logic [31:0] src_prev_q;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            src_meta_q <= gpc_pkg::RST_SRC;
            src_sync_q <= gpc_pkg::RST_SRC;
            src_prev_q <= gpc_pkg::RST_SRC;
        end else begin
            src_meta_q <= change_source_pins;
            src_sync_q <= src_meta_q;
            src_prev_q <= src_sync_q;
        end
    end

    // ****************************************
    // Pin-change groups
    // ****************************************
    logic [3:0] group_enable_q;
    logic [3:0] flags_q;
    logic [31:0] mask_q;
    logic [3:0] grp_hit;
    logic [3:0] grp_raw;
    logic gie;

    assign gie = cpu_status_q[gpc_pkg::POS_GLOBAL_IRQ_EN];

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            group_enable_q <= gpc_pkg::RST_GROUP_CONTROL;
        end else if (wr_gctl) begin
            group_enable_q <= reg_wdata[3:0];
        end
    end

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : grp
            always_ff @(posedge clk_sys) begin
                if (sys_rst) begin
                    mask_q[g*8 +: 8] <= gpc_pkg::RST_MASK;
                end else if (wr_mask[g]) begin
                    mask_q[g*8 +: 8] <= reg_wdata;
                end
            end

            // Unclocked view of enabled changes for wake-up from sleep
            assign grp_raw[g] = |((change_source_pins[g*8 +: 8] ^ src_sync_q[g*8 +: 8])
                                  & mask_q[g*8 +: 8]);
            assign grp_hit[g] = |((src_sync_q[g*8 +: 8] ^ src_prev_q[g*8 +: 8])
                                  & mask_q[g*8 +: 8]);

            // Set beats either clear in the same cycle
            always_ff @(posedge clk_sys) begin
                if (sys_rst) begin
                    flags_q[g] <= 1'b0;
                end else if (grp_hit[g]) begin
                    flags_q[g] <= 1'b1;
                end else if (vector_entered[g]) begin
                    flags_q[g] <= 1'b0;
                end else if (wr_flags && reg_wdata[g]) begin
                    flags_q[g] <= 1'b0;
                end
            end

            // Each group is qualified by its own enable bit
            always_ff @(posedge clk_sys) begin
                if (sys_rst) begin
                    vector_request[g] <= 1'b0;
                    wake_request[g] <= 1'b0;
                end else begin
                    vector_request[g] <= flags_q[g] && group_enable_q[g] && gie
                                         && !vector_entered[g];
                    wake_request[g] <= grp_raw[g] && group_enable_q[g] && gie;
                end
            end
        end
    endgenerate

    // ****************************************
    // Read path
    // ****************************************
    logic [7:0] rdata_d;

    always_comb begin
        rdata_d = 8'h00;
        if (reg_addr[1:0] == 2'h0) begin
            case (reg_addr[8:2])
                gpc_pkg::IDX_INPUT_PINS: rdata_d = pin_sync_q;
                gpc_pkg::IDX_DIRECTION: rdata_d = direction_q;
                gpc_pkg::IDX_OUTPUT_DATA: rdata_d = output_data_q;
                gpc_pkg::IDX_CORE_CONTROL: rdata_d = core_control_q;
                gpc_pkg::IDX_CPU_STATUS: rdata_d = cpu_status_q;
                gpc_pkg::IDX_GROUP_CONTROL: rdata_d = {4'h0, group_enable_q};
                gpc_pkg::IDX_GROUP_FLAGS: rdata_d = {4'h0, flags_q};
                gpc_pkg::IDX_MASK_GROUP0: rdata_d = mask_q[7:0];
                gpc_pkg::IDX_MASK_GROUP1: rdata_d = mask_q[15:8];
                gpc_pkg::IDX_MASK_GROUP2: rdata_d = mask_q[23:16];
                gpc_pkg::IDX_MASK_GROUP3: rdata_d = mask_q[31:24];
                default: rdata_d = 8'h00;
            endcase
        end
    end

    // Data stands for exactly the cycle after the read strobe
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rdata_d;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule

`default_nettype wire

//--- gpc_port_props.sv
// Checker of register, pin and vector behaviour at the ports of the port block
`timescale 1ns/1ps
`default_nettype none
module gpc_port_props (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [8:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pin_pullup,
    input wire logic [3:0] vector_entered,
    input wire logic [3:0] vector_request
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // No disable here: reset itself is the cause being checked
    chk_reset_hi_z: assert property (disable iff (1'b0)
        sys_rst |-> (pin_oe | pin_pullup) == 8'h00) else $error("pins driven during reset");
    chk_read_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("stray read data");
    chk_read_dir: assert property (reg_rd && reg_addr == 9'h004 |=> reg_rdata == pin_oe)
        else $error("direction read mismatch");
    chk_dir_write: assert property (reg_wr && reg_addr == 9'h004 |=> pin_oe == $past(reg_wdata))
        else $error("direction write not applied");
    chk_out_write: assert property (reg_wr && reg_addr == 9'h008 |=> pin_out == $past(reg_wdata))
        else $error("output write not applied");
    chk_pin_toggle: assert property (reg_wr && reg_addr == 9'h000
        |=> pin_out == ($past(pin_out) ^ $past(reg_wdata))) else $error("toggle wrong");
    chk_out_set: assert property (reg_wr && reg_addr == 9'h014
        |=> pin_out == ($past(pin_out) | $past(reg_wdata))) else $error("bit set wrong");
    chk_dir_clear: assert property (reg_wr && reg_addr == 9'h010
        |=> pin_oe == ($past(pin_oe) & ~$past(reg_wdata))) else $error("bit clear wrong");
    chk_pullup_off: assert property ((pin_pullup & (pin_oe | ~pin_out)) == 8'h00)
        else $error("pull-up on output or zero bit");
    chk_entry_drop: assert property (|vector_entered
        |=> (vector_request & $past(vector_entered)) == 4'h0) else $error("request after entry");
    chk_cfg_stable: assert property (!reg_wr |=> $stable(pin_oe))
        else $error("direction moved without write");
endmodule
bind gpc_port gpc_port_props u_gpc_port_props (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
    .vector_entered(vector_entered), .vector_request(vector_request));
`default_nettype wire

//--- gpc_pins_model.sv
// Board-side model of the eight port pins
`timescale 1ns/1ps
`default_nettype none
module gpc_pins_model (
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pin_pullup,
    output logic [7:0] pin_in
);
    // Weak board pull-down, so an undriven pin without pull-up reads low
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & pin_pullup);
endmodule
`default_nettype wire

//--- tb_gpc_port.sv
// Self-checking testbench of the port block
`timescale 1ns/1ps
`default_nettype none
module tb_gpc_port;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [8:0] reg_addr = 9'h000;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata, pin_out, pin_oe, pin_pullup, pin_in;
    logic [31:0] src = 32'h0000_0000;
    logic [3:0] entered = 4'h0;
    logic [3:0] vreq;
    logic [3:0] wake;
    logic [8:0] rst_addrs [7] = '{9'h004, 9'h008, 9'h02c, 9'h030, 9'h1b4, 9'h1cc, 9'h028};
    int mismatches = 0;
    int check_count = 0;
    always #50 clk_sys = ~clk_sys;
    gpc_port u_gpc_port (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
        .change_source_pins(src), .vector_entered(entered), .vector_request(vreq),
        .wake_request(wake));
    gpc_pins_model u_gpc_pins_model (.pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pullup(pin_pullup), .pin_in(pin_in));
    // ****************************************
    // Bus and compare helpers
    // ****************************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [8:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    task automatic complete_run;
        $display("mismatches %0d checks %0d", mismatches, check_count);
        if (mismatches == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset;
        repeat (3) @(posedge clk_sys);
        #1 chk(pin_oe | pin_pullup, 8'h00);
        repeat (3) @(posedge clk_sys);
        sys_rst <= 1'b0;
        foreach (rst_addrs[i]) rd(rst_addrs[i], 8'h00);
    endtask
    task automatic t_config;
        wr(9'h004, 8'h0f);
        wr(9'h008, 8'h35);
        chk(pin_oe, 8'h0f);
        chk(pin_pullup, 8'h30);
        repeat (3) @(posedge clk_sys);
        rd(9'h000, 8'h35);
        wr(9'h01c, 8'h10);
        chk(pin_pullup, 8'h00);
        repeat (3) @(posedge clk_sys);
        rd(9'h000, 8'h05);
        wr(9'h01c, 8'h00);
        wr(9'h014, 8'h40);
        chk(pin_pullup, 8'h70);
        wr(9'h00c, 8'h40);
        wr(9'h018, 8'h20);
        wr(9'h00c, 8'h20);
        chk(pin_oe, 8'h6f);
        chk(pin_out, 8'h55);
        chk(pin_pullup, 8'h10);
    endtask
    task automatic t_bits;
        wr(9'h000, 8'h81);
        rd(9'h008, 8'hd4);
        wr(9'h000, 8'h00);
        rd(9'h008, 8'hd4);
        wr(9'h010, 8'h01);
        rd(9'h004, 8'h6e);
        wr(9'h100, 8'hff);
        rd(9'h100, 8'h00);
        rd(9'h014, 8'h00);
        rd(9'h004, 8'h6e);
    endtask
    task automatic t_change;
        wr(9'h02c, 8'h08);
        wr(9'h1cc, 8'h01);
        wr(9'h024, 8'h09);
        wr(9'h020, 8'h80);
        @(posedge clk_sys);
        src <= 32'h0100_0018;
        @(posedge clk_sys);
        // Wake path sees the raw change before the synchronisers catch up
        #1 chk({4'h0, wake}, 8'h09);
        repeat (5) @(posedge clk_sys);
        rd(9'h028, 8'h09);
        chk({4'h0, vreq}, 8'h09);
        @(posedge clk_sys);
        entered <= 4'h1;
        @(posedge clk_sys);
        entered <= 4'h0;
        rd(9'h028, 8'h08);
        chk({4'h0, vreq}, 8'h08);
        wr(9'h028, 8'h00);
        rd(9'h028, 8'h08);
        wr(9'h020, 8'h00);
        repeat (2) @(posedge clk_sys);
        #1 chk({4'h0, vreq}, 8'h00);
        wr(9'h028, 8'h08);
        rd(9'h028, 8'h00);
        // Masked bit 4 falls, enabled bit 8 rises in a disabled group
        wr(9'h030, 8'h01);
        @(posedge clk_sys);
        src <= 32'h0100_0108;
        repeat (5) @(posedge clk_sys);
        rd(9'h028, 8'h02);
        chk({4'h0, vreq}, 8'h00);
    endtask
    initial begin
        t_reset();
        t_config();
        t_bits();
        t_change();
        complete_run();
    end
    // Run needs about 110 cycles; 5000 leaves ample margin
    initial begin
        #500000;
        mismatches++;
        complete_run();
    end
endmodule
`default_nettype wire
